// ### hw/bmd_pkg.sv
package bmd_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned BMD_CLK_MHZ = 125;
  localparam int unsigned BMD_SETTLE_US = 3000;
  localparam int unsigned BMD_SETTLE_CYC = BMD_SETTLE_US * BMD_CLK_MHZ;
  localparam int unsigned BMD_STEP_FAST_NS = 2000;
  localparam int unsigned BMD_STEP_SLOW_NS = 4000;
  localparam logic [8:0] BMD_STEP_FAST_CYC = 9'(BMD_STEP_FAST_NS * BMD_CLK_MHZ / 1000);
  localparam logic [8:0] BMD_STEP_SLOW_CYC = 9'(BMD_STEP_SLOW_NS * BMD_CLK_MHZ / 1000);
  localparam logic [18:0] BMD_SOFT_STEP_CYC = 19'h0007d;

  // ==========================================================
  // Set point code scale
  localparam int unsigned BMD_STEP_MV = 25;
  localparam int unsigned BMD_BASE_MV = 700;

  // ==========================================================
  // Field reset values, single-phase pair code and reserved frequency code
  localparam logic [3:0] BMD_MODE_RST = 4'h8;
  localparam logic [1:0] BMD_FREQ_RST = 2'h1;
  localparam logic [7:0] BMD_PHASE_RST = 8'h90;
  localparam logic [7:0] BMD_PHASE_QUAD_RST = 8'h50;
  localparam logic [1:0] BMD_PAIR_SINGLE = 2'h1;
  localparam logic [1:0] BMD_PAIR_INDEP = 2'h3;
  localparam logic [1:0] BMD_FREQ_RSVD = 2'h3;

  // ==========================================================
  // Host write field selects and config byte layout
  localparam logic [2:0] BMD_FLD_NORMAL = 3'h0;
  localparam logic [2:0] BMD_FLD_STANDBY = 3'h1;
  localparam logic [2:0] BMD_FLD_SLEEP = 3'h2;
  localparam logic [2:0] BMD_FLD_MODE = 3'h3;
  localparam logic [2:0] BMD_FLD_CONF = 3'h4;
  localparam int unsigned BMD_CONF_SLEEPEN = 0;
  localparam int unsigned BMD_CONF_RATE = 1;
  localparam int unsigned BMD_CONF_PHASE = 2;
  localparam int unsigned BMD_CONF_FREQ = 4;

  // ==========================================================
  // Switching modes and regulator states
  typedef enum logic [1:0] {
    BMD_SW_OFF = 2'b00,
    BMD_SW_PFM = 2'b01,
    BMD_SW_AUTO = 2'b10,
    BMD_SW_PWM = 2'b11
  } bmd_sw_t;

  typedef enum logic [2:0] {
    BMD_ST_OFF = 3'b000,
    BMD_ST_SOFT = 3'b001,
    BMD_ST_SETTLE = 3'b010,
    BMD_ST_ON = 3'b011,
    BMD_ST_SLEEP = 3'b100
  } bmd_state_t;

endpackage

// ### hw/bmd_ramp.sv
`timescale 1ns/10ps

module bmd_ramp
  import bmd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Control
  input wire logic load,
  input wire logic slowRate,
  input wire logic [4:0] goal,
  // Status
  output logic [4:0] cur,
  output logic busy
);

  typedef struct packed {
    logic [4:0] cur;
    logic [8:0] cnt;
    logic busy;
  } bmd_ramp_st_t;

  bmd_ramp_st_t st_q;
  bmd_ramp_st_t st_d;
  logic [8:0] lim;

  // ==========================================================
  // One code per interval toward the goal, then hold
  always_comb
  begin
    st_d = st_q;
    lim = slowRate ? BMD_STEP_SLOW_CYC : BMD_STEP_FAST_CYC;
    if (load)
    begin
      st_d.cur = goal;
      st_d.cnt = 9'h000;
      st_d.busy = 1'b0;
    end
    else if (st_q.cur != goal)
    begin
      st_d.busy = 1'b1;
      if (st_q.cnt == lim - 9'h001)
      begin
        st_d.cnt = 9'h000;
        st_d.cur = (goal > st_q.cur) ? st_q.cur + 5'h01 : st_q.cur - 5'h01;
      end
      else
      begin
        st_d.cnt = st_q.cnt + 9'h001;
      end
    end
    else
    begin
      st_d.busy = 1'b0;
      st_d.cnt = 9'h000;
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign cur = st_q.cur;
  assign busy = st_q.busy;

endmodule

// ### hw/bmd_ctrl.sv
`timescale 1ns/10ps

module bmd_ctrl
  import bmd_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = BMD_SETTLE_CYC
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Power events from the sequencer, same clock
  input wire logic turnOnEvt,
  input wire logic turnOffEvt,
  input wire logic [3:0] seqSlotGo,
  // Asynchronous status pins
  input wire logic standbyPin,
  input wire logic [3:0] inRegulation,
  // Start-up fuse load
  input wire logic fuseLoad,
  input wire logic [1:0] corePairConfigFuse,
  input wire logic [3:0][4:0] fusedVoltageCode,
  // Host setting writes
  input wire logic hostWrEn,
  input wire logic [1:0] hostWrReg,
  input wire logic [2:0] hostWrField,
  input wire logic [7:0] hostWrData,
  // Regulator controls
  output logic [3:0] regEnable,
  output logic [3:0] regDischarge,
  output logic [3:0][1:0] regSwMode,
  output logic [3:0][4:0] regTargetCode,
  output logic [3:0] regStepping,
  output logic [3:0][1:0] regPhaseQuad,
  output logic [3:0][1:0] regFreqSel,
  // Core pair configuration
  output logic coreSinglePhase,
  // Readback of held settings
  output logic [3:0][3:0] switchModeSelect,
  output logic [3:0] sleepEnableBit
);

  typedef struct packed {
    logic [3:0][4:0] normalSp;
    logic [3:0][4:0] standbySp;
    logic [3:0][4:0] sleepSp;
    logic [3:0][3:0] modeSel;
    logic [3:0] sleepEn;
    logic [3:0] rateSel;
    logic [3:0][1:0] phaseSel;
    logic [3:0][1:0] freqSel;
    bmd_state_t [3:0] pst;
    logic [3:0][18:0] tmr;
    logic [1:0] pairCfg;
    logic [2:0] stbySync;
    logic stbyStable;
    logic [2:0][3:0] regSync;
    logic [3:0] regStable;
    logic [3:0] oEn;
    logic [3:0] oDis;
    logic [3:0][1:0] oMode;
    logic [3:0][4:0] oTarget;
    logic [3:0] oStep;
    logic [3:0][1:0] oPhase;
    logic [3:0][1:0] oFreq;
    logic oSingle;
  } bmd_ctrl_st_t;

  bmd_ctrl_st_t st_q;
  bmd_ctrl_st_t st_d;
  logic [3:0] rampLoad;
  logic [3:0][4:0] rampGoal;
  logic [3:0][4:0] rampCur;
  logic [3:0] rampBusy;
  logic [3:0][1:0] liveMode;

  // ==========================================================
  // Helpers

  // Mode field to {normal, standby}; reserved codes fall back to auto
  function automatic logic [3:0] bmd_mode_decode(input logic [3:0] code);
    logic [3:0] r;
    r = {BMD_SW_AUTO, BMD_SW_AUTO};
    case (code)
      4'h0: r = {BMD_SW_OFF, BMD_SW_OFF};
      4'h1: r = {BMD_SW_PWM, BMD_SW_OFF};
      4'h3: r = {BMD_SW_PFM, BMD_SW_OFF};
      4'h4: r = {BMD_SW_AUTO, BMD_SW_OFF};
      4'h5: r = {BMD_SW_PWM, BMD_SW_PWM};
      4'h6: r = {BMD_SW_PWM, BMD_SW_AUTO};
      4'h8: r = {BMD_SW_AUTO, BMD_SW_AUTO};
      4'hc: r = {BMD_SW_AUTO, BMD_SW_PFM};
      4'hd: r = {BMD_SW_PWM, BMD_SW_PFM};
      default: r = {BMD_SW_AUTO, BMD_SW_AUTO};
    endcase
    return r;
  endfunction

  // Phase field to clock quadrant (0, 90, 90, 270 degrees)
  function automatic logic [1:0] bmd_phase_decode(input logic [1:0] code);
    logic [1:0] q;
    q = 2'h0;
    case (code)
      2'h0: q = 2'h0;
      2'h1: q = 2'h1;
      2'h2: q = 2'h1;
      2'h3: q = 2'h3;
      default: q = 2'h0;
    endcase
    return q;
  endfunction

  // ==========================================================
  // Step engines, one per regulator
  for (genvar g = 0; g < 4; g++)
  begin : gRamp
    bmd_ramp uRamp (
      .ref_clk(ref_clk),
      .srst(srst),
      .load(rampLoad[g]),
      .slowRate(st_q.rateSel[g]),
      .goal(rampGoal[g]),
      .cur(rampCur[g]),
      .busy(rampBusy[g])
    );
  end

  // Goal and live mode from regulator state
  always_comb
  begin
    logic [3:0] md;
    md = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      md = bmd_mode_decode(st_q.modeSel[i]);
      rampLoad[i] = (st_q.pst[i] == BMD_ST_OFF);
      rampGoal[i] = st_q.normalSp[i];
      liveMode[i] = BMD_SW_OFF;
      case (st_q.pst[i])
        BMD_ST_OFF: liveMode[i] = BMD_SW_OFF;
        BMD_ST_SOFT:
        begin
          if (st_q.tmr[i] < BMD_SOFT_STEP_CYC)
            liveMode[i] = BMD_SW_PFM;
          else if (st_q.tmr[i] < 19'(2 * BMD_SOFT_STEP_CYC))
            liveMode[i] = BMD_SW_AUTO;
          else
            liveMode[i] = BMD_SW_PWM;
        end
        BMD_ST_SETTLE: liveMode[i] = BMD_SW_PWM;
        BMD_ST_ON:
        begin
          if (st_q.stbyStable)
          begin
            rampGoal[i] = st_q.standbySp[i];
            liveMode[i] = md[1:0];
          end
          else
          begin
            liveMode[i] = md[3:2];
          end
        end
        BMD_ST_SLEEP:
        begin
          rampGoal[i] = st_q.sleepSp[i];
          liveMode[i] = BMD_SW_PFM;
        end
        default: liveMode[i] = BMD_SW_OFF;
      endcase
    end
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    int s;
    s = 0;
    st_d = st_q;

    // Three-stage synchronisers; change taken when stages two and three agree
    st_d.stbySync = {st_q.stbySync[1:0], standbyPin};
    if (st_q.stbySync[1] == st_q.stbySync[2])
      st_d.stbyStable = st_q.stbySync[2];
    st_d.regSync = {st_q.regSync[1:0], inRegulation};
    for (int i = 0; i < 4; i++)
    begin
      if (st_q.regSync[1][i] == st_q.regSync[2][i])
        st_d.regStable[i] = st_q.regSync[2][i];
    end

    // Start-up copy of fused codes
    if (fuseLoad)
    begin
      st_d.pairCfg = corePairConfigFuse;
      for (int i = 0; i < 4; i++)
      begin
        st_d.normalSp[i] = fusedVoltageCode[i];
        st_d.standbySp[i] = fusedVoltageCode[i];
        st_d.sleepSp[i] = fusedVoltageCode[i];
      end
    end

    // Host writes; new set points are reached through the step engine
    if (hostWrEn)
    begin
      case (hostWrField)
        BMD_FLD_NORMAL: st_d.normalSp[hostWrReg] = hostWrData[4:0];
        BMD_FLD_STANDBY: st_d.standbySp[hostWrReg] = hostWrData[4:0];
        BMD_FLD_SLEEP: st_d.sleepSp[hostWrReg] = hostWrData[4:0];
        BMD_FLD_MODE: st_d.modeSel[hostWrReg] = hostWrData[3:0];
        BMD_FLD_CONF:
        begin
          st_d.sleepEn[hostWrReg] = hostWrData[BMD_CONF_SLEEPEN];
          st_d.rateSel[hostWrReg] = hostWrData[BMD_CONF_RATE];
          st_d.phaseSel[hostWrReg] = hostWrData[BMD_CONF_PHASE +: 2];
          st_d.freqSel[hostWrReg] = hostWrData[BMD_CONF_FREQ +: 2];
        end
        default: st_d.sleepEn = st_q.sleepEn;
      endcase
    end

    // Per-regulator power state
    for (int i = 0; i < 4; i++)
    begin
      case (st_q.pst[i])
        BMD_ST_OFF:
        begin
          if (turnOnEvt)
          begin
            st_d.modeSel[i] = BMD_MODE_RST;
            st_d.normalSp[i] = fusedVoltageCode[i];
            st_d.standbySp[i] = fusedVoltageCode[i];
            st_d.sleepSp[i] = fusedVoltageCode[i];
          end
          if (seqSlotGo[i])
          begin
            st_d.pst[i] = BMD_ST_SOFT;
            st_d.tmr[i] = 19'h00000;
          end
        end
        BMD_ST_SOFT:
        begin
          if (st_q.tmr[i] < 19'(2 * BMD_SOFT_STEP_CYC))
            st_d.tmr[i] = st_q.tmr[i] + 19'h00001;
          else if (st_q.regStable[i])
          begin
            st_d.pst[i] = BMD_ST_SETTLE;
            st_d.tmr[i] = 19'h00000;
          end
        end
        BMD_ST_SETTLE:
        begin
          if (st_q.tmr[i] == 19'(SETTLE_CYC - 1))
            st_d.pst[i] = BMD_ST_ON;
          else
            st_d.tmr[i] = st_q.tmr[i] + 19'h00001;
        end
        BMD_ST_ON: st_d.pst[i] = BMD_ST_ON;
        BMD_ST_SLEEP:
        begin
          if (turnOnEvt)
          begin
            if (st_q.sleepEn[i])
              st_d.pst[i] = BMD_ST_ON;
            else
            begin
              st_d.pst[i] = BMD_ST_OFF;
              st_d.modeSel[i] = BMD_MODE_RST;
              st_d.normalSp[i] = fusedVoltageCode[i];
              st_d.standbySp[i] = fusedVoltageCode[i];
              st_d.sleepSp[i] = fusedVoltageCode[i];
            end
          end
        end
        default: st_d.pst[i] = BMD_ST_OFF;
      endcase
      // Turn-off event from any running state
      if (turnOffEvt && st_q.pst[i] != BMD_ST_OFF && st_q.pst[i] != BMD_ST_SLEEP)
        st_d.pst[i] = st_q.sleepEn[i] ? BMD_ST_SLEEP : BMD_ST_OFF;
    end

    // Registered outputs; core B mirrors core A's mode, enable, discharge, target and stepping in single phase
    st_d.oSingle = (st_q.pairCfg == BMD_PAIR_SINGLE);
    for (int i = 0; i < 4; i++)
    begin
      s = (i == 1 && st_q.pairCfg == BMD_PAIR_SINGLE) ? 0 : i;
      st_d.oMode[i] = liveMode[s];
      st_d.oEn[i] = (liveMode[s] != BMD_SW_OFF);
      st_d.oDis[i] = (liveMode[s] == BMD_SW_OFF);
      st_d.oTarget[i] = rampCur[s];
      st_d.oStep[i] = rampBusy[s];
      st_d.oPhase[i] = bmd_phase_decode(st_q.phaseSel[i]);
      st_d.oFreq[i] = (st_q.freqSel[i] == BMD_FREQ_RSVD) ? BMD_FREQ_RST : st_q.freqSel[i];
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_q <= '0;
      st_q.modeSel <= {4{BMD_MODE_RST}};
      st_q.freqSel <= {4{BMD_FREQ_RST}};
      st_q.phaseSel <= BMD_PHASE_RST;
      st_q.oPhase <= BMD_PHASE_QUAD_RST;
      st_q.pairCfg <= BMD_PAIR_INDEP;
      st_q.oDis <= 4'hf;
      st_q.oFreq <= {4{BMD_FREQ_RST}};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  assign regEnable = st_q.oEn;
  assign regDischarge = st_q.oDis;
  assign regSwMode = st_q.oMode;
  assign regTargetCode = st_q.oTarget;
  assign regStepping = st_q.oStep;
  assign regPhaseQuad = st_q.oPhase;
  assign regFreqSel = st_q.oFreq;
  assign coreSinglePhase = st_q.oSingle;
  assign switchModeSelect = st_q.modeSel;
  assign sleepEnableBit = st_q.sleepEn;

endmodule

// ### tb/bmd_ctrl_sva.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker
module bmd_ctrl_chk
  import bmd_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = BMD_SETTLE_CYC
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Events and writes
  input wire logic turnOnEvt,
  input wire logic turnOffEvt,
  input wire logic fuseLoad,
  input wire logic hostWrEn,
  input wire logic [1:0] hostWrReg,
  input wire logic [2:0] hostWrField,
  input wire logic [7:0] hostWrData,
  // Regulator outputs
  input wire logic [3:0] regEnable,
  input wire logic [3:0] regDischarge,
  input wire logic [3:0][1:0] regSwMode,
  input wire logic [3:0][4:0] regTargetCode,
  input wire logic [3:0] regStepping,
  input wire logic [3:0][1:0] regPhaseQuad,
  input wire logic [3:0][1:0] regFreqSel,
  input wire logic coreSinglePhase,
  input wire logic [3:0][3:0] switchModeSelect,
  input wire logic [3:0] sleepEnableBit
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  logic [15:0] dataQ;
  logic [9:0] gapQ;
  // Write data history, cycles since last target move
  always_ff @(posedge ref_clk)
  begin
    dataQ <= {dataQ[7:0], hostWrData};
    if (srst || $changed(regTargetCode[2]))
      gapQ <= 10'h0;
    else if (gapQ != 10'h3ff)
      gapQ <= gapQ + 10'h1;
  end
  a_dis_inverse: assert property (
    regDischarge == ~regEnable) else $error("discharge not inverse of enable");
  a_off_mode: assert property (
    !regEnable[2] |-> regSwMode[2] == BMD_SW_OFF) else $error("disabled but switching");
  a_step_one: assert property (
    $changed(regTargetCode[2]) && $past(regStepping[2]) && regEnable[2] |->
    (regTargetCode[2] - $past(regTargetCode[2]) == 5'h1) ||
    ($past(regTargetCode[2]) - regTargetCode[2] == 5'h1)) else $error("step not one code");
  a_step_gap: assert property (
    $changed(regTargetCode[2]) && $past(regStepping[2]) && regEnable[2] |->
    gapQ >= 10'd249) else $error("steps too close");
  a_sleep_pfm: assert property (
    turnOffEvt && sleepEnableBit[2] && regEnable[2] |->
    ##2 regEnable[2] && regSwMode[2] == BMD_SW_PFM) else $error("sleep not pfm");
  a_off_event: assert property (
    turnOffEvt && !sleepEnableBit[2] && regEnable[2] && regSwMode[2] != BMD_SW_PFM |->
    ##2 !regEnable[2]) else $error("turn-off left regulator on");
  a_phase_dec: assert property (
    hostWrEn && hostWrField == BMD_FLD_CONF && hostWrReg == 2'h3 |-> ##2
    regPhaseQuad[3] == (dataQ[11:10] == 2'h2 ? 2'h1 : dataQ[11:10]))
    else $error("phase decode wrong");
  a_freq_dec: assert property (
    hostWrEn && hostWrField == BMD_FLD_CONF && hostWrReg == 2'h3 |-> ##2
    regFreqSel[3] == (dataQ[13:12] == 2'h3 ? 2'h1 : dataQ[13:12]))
    else $error("frequency decode wrong");
  a_mode_store: assert property (
    hostWrEn && hostWrField == BMD_FLD_MODE && hostWrReg == 2'h2 && !turnOnEvt && !fuseLoad
    |=> switchModeSelect[2] == dataQ[3:0]) else $error("mode field not stored");
  a_pair_copy: assert property (
    coreSinglePhase && $past(coreSinglePhase) |-> regEnable[1] == regEnable[0] &&
    regSwMode[1] == regSwMode[0] && regTargetCode[1] == regTargetCode[0])
    else $error("core b differs in single phase");
endmodule

// ### tb/bmd_host_model.sv
`timescale 1ns/10ps
// ==========================================================
// Host writing regulator settings
module bmd_host_model
  import bmd_pkg::*;
(
  // Clock and status
  input wire logic ref_clk,
  input wire logic coreSinglePhase,
  input wire logic [3:0] regStepping,
  // Write strobe
  output logic hostWrEn,
  output logic [1:0] hostWrReg,
  output logic [2:0] hostWrField,
  output logic [7:0] hostWrData,
  // Overcurrent mask
  output logic ocMask
);
  // Mask overcurrent while a ramp runs
  assign ocMask = |regStepping;
  // Idle strobe
  initial
  begin
    {hostWrEn, hostWrReg, hostWrField, hostWrData} = 14'h0;
  end
  // One field per write; config writes to reg 0 mirrored to core b in single phase
  task automatic wr(input logic [1:0] r, input logic [2:0] f, input logic [7:0] d);
    int n;
    n = (coreSinglePhase && r == 2'h0 && f == BMD_FLD_CONF) ? 2 : 1;
    if (r == 2'h0 && f < BMD_FLD_MODE && d[4:0] > 5'h1d)
      return;
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      {hostWrEn, hostWrReg, hostWrField, hostWrData} <= {1'b1, r | 2'(i), f, d};
      @(posedge ref_clk);
      hostWrEn <= 1'b0;
      hostWrData <= ~d;
    end
  endtask
endmodule

// ### tb/bmd_ctrl_tb_top.sv
`timescale 1ns/10ps
// ==========================================================
// Bench top
module bmd_ctrl_tb_top
  import bmd_pkg::*;
;
  localparam int SETTLE = 20;
  logic ref_clk, srst, turnOnEvt, turnOffEvt, standbyPin, fuseLoad, hostWrEn;
  logic [3:0] seqSlotGo, regEnable, regDischarge, regStepping, sleepEnableBit, inRegulation;
  logic [1:0] corePairConfigFuse, hostWrReg;
  logic [2:0] hostWrField;
  logic [7:0] hostWrData;
  logic [3:0][4:0] fusedVoltageCode, regTargetCode;
  logic [3:0][1:0] regSwMode, regPhaseQuad, regFreqSel;
  logic [3:0][3:0] switchModeSelect;
  logic coreSinglePhase;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  // Design and host
  bmd_ctrl #(.SETTLE_CYC(SETTLE)) u_dut (.ref_clk, .srst, .turnOnEvt, .turnOffEvt,
    .seqSlotGo, .standbyPin, .inRegulation, .fuseLoad, .corePairConfigFuse,
    .fusedVoltageCode, .hostWrEn, .hostWrReg, .hostWrField, .hostWrData, .regEnable,
    .regDischarge, .regSwMode, .regTargetCode, .regStepping, .regPhaseQuad, .regFreqSel,
    .coreSinglePhase, .switchModeSelect, .sleepEnableBit);
  bmd_host_model u_host (.ref_clk, .coreSinglePhase, .regStepping, .hostWrEn, .hostWrReg,
    .hostWrField, .hostWrData, .ocMask());
  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      test_done();
    end
  end
  // ==========================================================
  // Helpers
  task automatic test_done();
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic nd(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic pulse(input logic [6:0] v);
    @(posedge ref_clk);
    {fuseLoad, turnOnEvt, turnOffEvt, seqSlotGo} <= v;
    @(posedge ref_clk);
    {fuseLoad, turnOnEvt, turnOffEvt, seqSlotGo} <= 7'h0;
  endtask
  task automatic run(input logic [1:0] m, output int n);
    n = 0;
    while (regSwMode[2] === m && n < 1000)
    begin
      nd(1);
      n++;
    end
  endtask
  task automatic chg(output int n);
    logic [4:0] t;
    t = regTargetCode[2];
    n = 0;
    while (regTargetCode[2] === t && n < 2000)
    begin
      nd(1);
      n++;
    end
  endtask
  task automatic stby(input logic s);
    @(posedge ref_clk);
    standbyPin <= s;
  endtask
  // Expected normal or standby switching mode
  function automatic logic [1:0] dec(input logic [3:0] c, input logic s);
    case (c)
      4'h0: dec = 2'h0;
      4'h1: dec = s ? 2'h0 : 2'h3;
      4'h3: dec = s ? 2'h0 : 2'h1;
      4'h4: dec = s ? 2'h0 : 2'h2;
      4'h5: dec = 2'h3;
      4'h6: dec = s ? 2'h2 : 2'h3;
      4'hc: dec = s ? 2'h1 : 2'h2;
      4'hd: dec = s ? 2'h1 : 2'h3;
      default: dec = 2'h2;
    endcase
  endfunction
  // ==========================================================
  // Scenarios
  task automatic t_start();
    int n;
    cmp(32'(regDischarge), 32'hf);
    cmp(32'({regPhaseQuad, regFreqSel, switchModeSelect}), 32'h50558888);
    pulse(7'h40);
    nd(4);
    cmp(32'({coreSinglePhase, regTargetCode}), 32'(fusedVoltageCode));
    pulse(7'h04);
    nd(3);
    cmp(32'({regEnable[2], regSwMode[2]}), 32'h5);
    run(2'h1, n);
    cmp(32'(n >= 122 && n <= 125), 32'h1);
    run(2'h2, n);
    cmp(32'(n), 32'd125);
    nd(10);
    cmp(32'(regSwMode[2]), 32'h3);
    @(posedge ref_clk);
    inRegulation <= 4'hf;
    run(2'h3, n);
    cmp(32'({n >= SETTLE + 5 && n <= SETTLE + 8, regSwMode[2]}), 32'h6);
  endtask
  task automatic t_modes();
    logic [1:0] e;
    for (int c = 0; c < 16; c++)
    begin
      e = dec(4'(c), 1'b0);
      u_host.wr(2'h2, BMD_FLD_MODE, 8'(c));
      nd(4);
      cmp(32'({regDischarge[2], regSwMode[2]}), 32'({e == 2'h0, e}));
      stby(1'b1);
      nd(8);
      cmp(32'(regSwMode[2]), 32'(dec(4'(c), 1'b1)));
      stby(1'b0);
      nd(8);
      cmp(32'(regSwMode[2]), 32'(e));
    end
    u_host.wr(2'h2, BMD_FLD_MODE, 8'h08);
  endtask
  task automatic t_dvs();
    int n;
    u_host.wr(2'h2, BMD_FLD_NORMAL, 8'h0b);
    chg(n);
    chg(n);
    cmp(32'(n), 32'd250);
    chg(n);
    cmp(32'(n), 32'd250);
    nd(3);
    cmp(32'({regStepping[2], regTargetCode[2]}), 32'h0b);
    u_host.wr(2'h2, BMD_FLD_CONF, 8'h02);
    u_host.wr(2'h2, BMD_FLD_STANDBY, 8'h09);
    stby(1'b1);
    chg(n);
    chg(n);
    cmp(32'(n), 32'd500);
    nd(3);
    cmp(32'({regStepping[2], regTargetCode[2]}), 32'h09);
    stby(1'b0);
    chg(n);
    chg(n);
    cmp(32'({n, regTargetCode[2]}), 32'({32'd500, 5'h0b}));
  endtask
  task automatic t_conf();
    for (int k = 0; k < 4; k++)
    begin
      u_host.wr(2'h3, BMD_FLD_CONF, {2'h0, 2'(3 - k), 2'(k), 2'h0});
      nd(3);
      cmp(32'({regPhaseQuad[3], regFreqSel[3]}),
        32'({k == 2 ? 2'h1 : 2'(k), k == 0 ? 2'h1 : 2'(3 - k)}));
    end
  endtask
  task automatic t_sleep();
    int n;
    u_host.wr(2'h2, BMD_FLD_CONF, 8'h01);
    nd(1);
    cmp(32'(sleepEnableBit), 32'h4);
    u_host.wr(2'h2, BMD_FLD_SLEEP, 8'h0a);
    pulse(7'h10);
    nd(3);
    cmp(32'({regEnable[2], regSwMode[2]}), 32'h5);
    chg(n);
    cmp(32'(regTargetCode[2]), 32'h0a);
    pulse(7'h20);
    nd(3);
    cmp(32'({regEnable[2], regSwMode[2]}), 32'h6);
    chg(n);
    cmp(32'(regTargetCode[2]), 32'h0b);
    u_host.wr(2'h2, BMD_FLD_CONF, 8'h00);
    u_host.wr(2'h2, BMD_FLD_MODE, 8'h05);
    pulse(7'h10);
    nd(3);
    cmp(32'({regEnable[2], regDischarge[2]}), 32'h1);
    pulse(7'h20);
    nd(3);
    cmp(32'({switchModeSelect[2], regTargetCode[2], regEnable[2]}), 32'h210);
  endtask
  task automatic t_pair();
    logic [5:0] fz;
    fz = 6'h0b;
    @(posedge ref_clk);
    corePairConfigFuse <= 2'h1;
    pulse(7'h40);
    nd(2);
    u_host.wr(2'h0, BMD_FLD_CONF, 8'h1c);
    pulse(7'h01);
    nd(4);
    cmp(32'({coreSinglePhase, regEnable[1:0], regPhaseQuad[1]}), 32'h1f);
    for (int f = 0; f < 3; f++)
    begin
      @(posedge ref_clk);
      corePairConfigFuse <= fz[2 * f +: 2];
      pulse(7'h40);
      nd(4);
      cmp(32'({coreSinglePhase, regEnable[1]}), 32'h0);
    end
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    srst = 1'b1;
    {fuseLoad, turnOnEvt, turnOffEvt, seqSlotGo, standbyPin, inRegulation} = 12'h000;
    corePairConfigFuse = 2'h3;
    fusedVoltageCode = {5'h0c, 5'h08, 5'h0a, 5'h06};
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    nd(1);
    t_start();
    t_modes();
    t_dvs();
    t_conf();
    t_sleep();
    t_pair();
    test_done();
  end
endmodule

bind bmd_ctrl bmd_ctrl_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.ref_clk, .srst, .turnOnEvt,
  .turnOffEvt, .fuseLoad, .hostWrEn, .hostWrReg, .hostWrField, .hostWrData, .regEnable,
  .regDischarge, .regSwMode, .regTargetCode, .regStepping, .regPhaseQuad, .regFreqSel,
  .coreSinglePhase, .switchModeSelect, .sleepEnableBit);
